// ==== tb/udms_top_tb.sv ====
// Self-checking bench for the unsigned divide, multiply, saturate and extend datapath
`timescale 1ns/1ps
`default_nettype none

module udms_top_tb;
    logic clk; // 100 MHz core clock
    logic reset_n; // Active-low reset
    logic instr_valid, instr_is_16, div_zero_trap_enable, sat_flag_clr;
    logic [31:0] instr, rf_val_n, rf_val_m, rf_val_dlo, rf_val_dhi; // Bench acts as register file
    logic [3:0] rf_addr_n, rf_addr_m, rf_addr_dlo, rf_addr_dhi;
    logic wb_lo_en, wb_hi_en;
    logic [3:0] wb_lo_addr, wb_hi_addr;
    logic [31:0] wb_lo_data, wb_hi_data;
    logic sticky_saturation_flag, usage_fault_exception, undefined_instr, unpredictable_op;
    int miscompares, check_count, cycles; // Verdict counters and hang guard
    logic sticky_exp; // Expected sticky flag, accumulated by the bench
    logic [63:0] dd; // Doubled word used to model rotation
    udms_top udms_top_i (.clk(clk), .reset_n(reset_n), .instr_valid(instr_valid),
        .instr_is_16(instr_is_16), .instr(instr), .rf_val_n(rf_val_n), .rf_val_m(rf_val_m),
        .rf_val_dlo(rf_val_dlo), .rf_val_dhi(rf_val_dhi),
        .div_zero_trap_enable(div_zero_trap_enable), .sat_flag_clr(sat_flag_clr),
        .rf_addr_n(rf_addr_n), .rf_addr_m(rf_addr_m), .rf_addr_dlo(rf_addr_dlo),
        .rf_addr_dhi(rf_addr_dhi), .wb_lo_en(wb_lo_en), .wb_lo_addr(wb_lo_addr),
        .wb_lo_data(wb_lo_data), .wb_hi_en(wb_hi_en), .wb_hi_addr(wb_hi_addr),
        .wb_hi_data(wb_hi_data), .sticky_saturation_flag(sticky_saturation_flag),
        .usage_fault_exception(usage_fault_exception), .undefined_instr(undefined_instr),
        .unpredictable_op(unpredictable_op));
    ////////////////////////////////////////////////////////////////////////////////
    // Encoders, built from fixed opcode bits and register fields
    function automatic logic [31:0] enc_div(input logic [3:0] rd, rn, rm);
        return {12'hfbb, rn, 4'hf, rd, 4'hf, rm};
    endfunction
    function automatic logic [31:0] enc_mul(input logic acc, input logic [3:0] rn, lo, hi, rm);
        return {(acc ? 12'hfbe : 12'hfba), rn, lo, hi, 4'h0, rm};
    endfunction
    function automatic logic [31:0] enc_sat(input logic sh, input logic [4:0] amt,
                                            input logic [3:0] rd, rn, input logic [4:0] n);
        return {5'h1e, 1'b0, 4'he, sh, 1'b0, rn, 1'b0, amt[4:2], rd, amt[1:0], 1'b0, n};
    endfunction
    function automatic logic [31:0] enc_ext(input logic half, input logic [3:0] rd,
                                            input logic [1:0] rot, input logic [3:0] rm);
        return {(half ? 16'hfa1f : 16'hfa5f), 4'hf, rd, 2'h2, rot, rm};
    endfunction
    // Reference clamp; bit 32 tells whether clamping happened
    function automatic logic [32:0] sat_exp(input logic [31:0] v, input logic sh,
                                            input logic [4:0] amt, input logic [4:0] n);
        logic signed [31:0] s;
        logic signed [32:0] lim;
        if (sh) begin
            s = $signed(v) >>> amt;
        end else begin
            s = v << amt;
        end
        lim = (33'sh1 <<< n) - 33'sh1;
        if (s < 0) begin
            return {1'b1, 32'h0};
        end else if (s > lim) begin
            return {1'b1, lim[31:0]};
        end
        return {1'b0, s};
    endfunction
    ////////////////////////////////////////////////////////////////////////////////
    // Compare, closing report and the one-operation access task
    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        check_count++;
        if (got !== exp) begin
            miscompares++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic conclude();
        if (miscompares == 0 && check_count > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    // Issue, answer register reads one cycle later, check pulses two cycles later.
    // Operand values arrive only in the read cycle, so a decoder that reads early fails.
    task automatic run(input logic is16, input logic [31:0] ins, input logic [127:0] vals,
                       input logic [15:0] amask, input logic [15:0] aexp,
                       input logic [4:0] fl, input logic [35:0] lo, input logic [35:0] hi);
        @(posedge clk);
        #1;
        instr_valid = 1'b1;
        instr_is_16 = is16;
        instr = ins;
        @(posedge clk);
        #1;
        instr_valid = 1'b0;
        {rf_val_n, rf_val_m, rf_val_dlo, rf_val_dhi} = vals;
        chk({48'h0, {rf_addr_n, rf_addr_m, rf_addr_dlo, rf_addr_dhi} & amask},
            {48'h0, aexp & amask});
        @(posedge clk);
        #1;
        // Flags: lo write, hi write, fault, undefined, unpredictable
        chk({59'h0, wb_lo_en, wb_hi_en, usage_fault_exception, undefined_instr,
             unpredictable_op}, {59'h0, fl});
        if (fl[4]) begin
            chk({28'h0, wb_lo_addr, wb_lo_data}, {28'h0, lo});
        end
        if (fl[3]) begin
            chk({28'h0, wb_hi_addr, wb_hi_data}, {28'h0, hi});
        end
        {rf_val_n, rf_val_m, rf_val_dlo, rf_val_dhi} = ~vals; // Stale read port value
    endtask
    task automatic sat_case(input logic [31:0] v, input logic sh, input logic [4:0] amt,
                            input logic [4:0] n);
        logic [32:0] e;
        e = sat_exp(v, sh, amt, n);
        sticky_exp = sticky_exp | e[32];
        run(1'b0, enc_sat(sh, amt, 4'h1, 4'h2, n), {v, 96'h0}, 16'hf000, 16'h2000, 5'h10,
            {4'h1, e[31:0]}, 36'h0);
        chk({63'h0, sticky_saturation_flag}, {63'h0, sticky_exp});
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    // Clock and hang guard; a generous ceiling, the run needs about 110 cycles
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    initial begin
        cycles = 0;
        forever begin
            @(posedge clk);
            cycles++;
            if (cycles == 5000) begin
                miscompares++;
                conclude();
            end
        end
    end
    ////////////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        {instr_valid, instr_is_16, div_zero_trap_enable, sat_flag_clr} = 4'h0;
        {instr, rf_val_n, rf_val_m, rf_val_dlo, rf_val_dhi} = 160'h0;
        miscompares = 0;
        check_count = 0;
        reset_n = 1'b0;
        repeat (10) @(posedge clk);
        #1;
        reset_n = 1'b1;
        repeat (3) @(posedge clk);
        #1;
        chk({59'h0, wb_lo_en, wb_hi_en, usage_fault_exception, undefined_instr,
             sticky_saturation_flag}, 64'h0);
        // Divide: quotient, truncation, zero divisor, trap, unpredictable register
        run(1'b0, enc_div(4'h2, 4'h3, 4'h4), {32'h64, 32'h7, 64'h0}, 16'hff00, 16'h3400, 5'h10, {4'h2, 32'he}, 36'h0);
        run(1'b0, enc_div(4'h5, 4'h6, 4'h7), {32'hffffffff, 32'h10, 64'h0}, 16'hff00, 16'h6700, 5'h10, {4'h5, 32'h0fffffff}, 36'h0);
        run(1'b0, enc_div(4'h2, 4'h3, 4'h4), {32'h1234, 32'h0, 64'h0}, 16'h0, 16'h0, 5'h10, {4'h2, 32'h0}, 36'h0);
        div_zero_trap_enable = 1'b1;
        run(1'b0, enc_div(4'h2, 4'h3, 4'h4), {32'h1234, 32'h0, 64'h0}, 16'h0, 16'h0, 5'h04, 36'h0, 36'h0);
        run(1'b0, enc_div(4'h2, 4'h3, 4'h4), {32'h9, 32'h3, 64'h0}, 16'h0, 16'h0, 5'h10, {4'h2, 32'h3}, 36'h0);
        div_zero_trap_enable = 1'b0;
        run(1'b0, enc_div(4'hd, 4'h3, 4'h4), {32'h9, 32'h2, 64'h0}, 16'h0, 16'h0, 5'h11, {4'hd, 32'h4}, 36'h0);
        // Long multiplies, with carry across the halves of the accumulate
        run(1'b0, enc_mul(1'b0, 4'h1, 4'h5, 4'h6, 4'h2), {32'hffffffff, 32'hffffffff, 64'h0}, 16'hff00, 16'h1200, 5'h18, {4'h5, 32'h1}, {4'h6, 32'hfffffffe});
        run(1'b0, enc_mul(1'b1, 4'h1, 4'h5, 4'h6, 4'h2), {32'hffffffff, 32'hffffffff, 32'hffffffff, 32'hffffffff}, 16'hffff, 16'h1256, 5'h18, {4'h5, 32'h0}, {4'h6, 32'hfffffffe});
        run(1'b0, enc_mul(1'b1, 4'h1, 4'h7, 4'h7, 4'h2), {32'h2, 32'h3, 64'h0}, 16'h0, 16'h0, 5'h19, {4'h7, 32'h6}, {4'h7, 32'h0});
        // Encodings with a wrong fixed bit are ignored
        run(1'b0, 32'h0, 128'h0, 16'h0, 16'h0, 5'h00, 36'h0, 36'h0);
        run(1'b0, enc_div(4'h2, 4'h3, 4'h4) & 32'hffffffef, {32'h9, 32'h3, 64'h0}, 16'h0, 16'h0, 5'h00, 36'h0, 36'h0);
        // Saturate: clear sticky flag first, then edge cases of shift and width
        @(posedge clk);
        #1;
        sat_flag_clr = 1'b1;
        @(posedge clk);
        #1;
        sat_flag_clr = 1'b0;
        sticky_exp = 1'b0;
        sat_case(32'h5, 1'b0, 5'h0, 5'h3);
        sat_case(32'h9, 1'b0, 5'h0, 5'h3);
        sat_case(32'hfffffff0, 1'b0, 5'h0, 5'h8);
        sat_case(32'h1, 1'b0, 5'h1f, 5'h1f);
        sat_case(32'h80000000, 1'b1, 5'h1f, 5'h4);
        sat_case(32'h00000f00, 1'b1, 5'h4, 5'h1f);
        sat_case(32'h7fffffff, 1'b0, 5'h0, 5'h1f);
        sat_case(32'h1, 1'b0, 5'h0, 5'h0);
        run(1'b0, enc_sat(1'b1, 5'h0, 4'h1, 4'h2, 5'h5), {32'h80000000, 96'h0}, 16'h0, 16'h0, 5'h02, 36'h0, 36'h0);
        chk({63'h0, sticky_saturation_flag}, {63'h0, sticky_exp});
        // Clear held through a clamping saturate: the set must win
        sat_flag_clr = 1'b1;
        sat_case(32'h9, 1'b0, 5'h0, 5'h3);
        sat_flag_clr = 1'b0;
        @(posedge clk);
        #1;
        sat_flag_clr = 1'b1;
        @(posedge clk);
        #1;
        sat_flag_clr = 1'b0;
        sticky_exp = 1'b0;
        chk({63'h0, sticky_saturation_flag}, {63'h0, sticky_exp});
        // Extends: every rotation, both widths, then the narrow forms
        for (int r = 0; r < 4; r++) begin
            dd = {32'h88776655, 32'h88776655} >> (r * 8);
            run(1'b0, enc_ext(1'b0, 4'h3, 2'(r), 4'h9), {32'h0, 32'h88776655, 64'h0}, 16'h0f00, 16'h0900, 5'h10, {4'h3, 24'h0, dd[7:0]}, 36'h0);
            run(1'b0, enc_ext(1'b1, 4'h4, 2'(r), 4'h8), {32'h0, 32'h88776655, 64'h0}, 16'h0f00, 16'h0800, 5'h10, {4'h4, 16'h0, dd[15:0]}, 36'h0);
        end
        run(1'b1, {16'h0, 10'h2cb, 3'h5, 3'h6}, {32'h0, 32'h88776655, 64'h0}, 16'h0f00, 16'h0500, 5'h10, {4'h6, 32'h55}, 36'h0);
        run(1'b1, {16'h0, 10'h2ca, 3'h1, 3'h2}, {32'h0, 32'h88776655, 64'h0}, 16'h0f00, 16'h0100, 5'h10, {4'h2, 32'h6655}, 36'h0);
        conclude();
    end
endmodule // udms_top_tb

`default_nettype wire

// ==== verilog/udms_pkg.sv ====
// Types shared by the unsigned datapath
`default_nettype none
package udms_pkg;
    // Operation selected by the decoder
    typedef enum logic [2:0] {
        op_none,
        op_unsigned_divide,
        op_unsigned_mul_acc_long,
        op_unsigned_mul_long,
        op_unsigned_saturate,
        op_zero_extend_byte,
        op_zero_extend_half
    } udms_op_t;
endpackage

`default_nettype wire

// ==== verilog/udms_regs.svh ====
// Opcode patterns and field positions for the unsigned datapath
`ifndef UDMS_REGS_SVH
`define UDMS_REGS_SVH
// Fixed opcode bits of the first halfword (bits 15:4)
`define UDMS_DIV_HW1 12'hfbb
`define UDMS_MLAL_HW1 12'hfbe
`define UDMS_MULL_HW1 12'hfba
// Full first halfword of the wide extend forms
`define UDMS_XTB_HW1 16'hfa5f
`define UDMS_XTH_HW1 16'hfa1f
// Saturate: bits 15:11 and 9:6 of the first halfword
`define UDMS_SAT_HI5 5'h1e
`define UDMS_SAT_MID4 4'he
// Narrow extend forms, bits 15:6
`define UDMS_XTB16 10'h2cb
`define UDMS_XTH16 10'h2ca
// Registers that make an encoding unpredictable
`define UDMS_REG_SP 4'hd
`define UDMS_REG_PC 4'hf
// Reset values
`define UDMS_RST_SAT 1'h0
`endif

// ==== verilog/udms_top.sv ====
// Unsigned divide, long multiply, saturate and zero-extend datapath
//
// Operation
// (RULE_01) Divide unsigned, quotient out, flags untouched
// (RULE_02) Divide register numbers from three nibble fields
// (RULE_03) Divide with r13/r15 executes, flagged unpredictable
// (RULE_04) Zero divisor: fault if trapping, else zero
// (RULE_05) Quotient truncated, low 32 bits written
// (RULE_06) Accumulate long adds 64-bit pair to product
// (RULE_07) Multiply long gives full 64-bit product
// (RULE_08) Low product word to low, high to high
// (RULE_09) No flags; equal or r13/r15 destinations unpredictable
// (RULE_10) Saturate signed operand into zero to 2^n-1
// (RULE_11) Clamping sets sticky flag, never clears it
// (RULE_12) Saturate arithmetic shift by zero is undefined
// (RULE_13) Pre-shift left 0-31 or arithmetic right 1-31
// (RULE_14) Byte extend: rotate, keep byte, zero-extend
// (RULE_15) Wide extend rotation is field times eight
// (RULE_16) Narrow byte extend: no rotation, low registers
// (RULE_17) Halfword extend: rotate, keep halfword, zero-extend
// (RULE_18) Decode fixed opcode bits, ignore should-be bits
// (RULE_19) Trap enable is a static input, sampled at execute
`timescale 1ns/1ps
`include "udms_regs.svh"
`default_nettype none

module udms_top (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic instr_valid,
    input wire logic instr_is_16,
    input wire logic [31:0] instr,
    input wire logic [31:0] rf_val_n,
    input wire logic [31:0] rf_val_m,
    input wire logic [31:0] rf_val_dlo,
    input wire logic [31:0] rf_val_dhi,
    input wire logic div_zero_trap_enable,
    input wire logic sat_flag_clr,
    output logic [3:0] rf_addr_n,
    output logic [3:0] rf_addr_m,
    output logic [3:0] rf_addr_dlo,
    output logic [3:0] rf_addr_dhi,
    output logic wb_lo_en,
    output logic [3:0] wb_lo_addr,
    output logic [31:0] wb_lo_data,
    output logic wb_hi_en,
    output logic [3:0] wb_hi_addr,
    output logic [31:0] wb_hi_data,
    output logic sticky_saturation_flag,
    output logic usage_fault_exception,
    output logic undefined_instr,
    output logic unpredictable_op
);

    ////////////////////////////////////////////////////////////////////////
    // Reset synchroniser
    logic [1:0] rst_sync_r; // Release shifts through two stages
    logic rst_n; // Synchronised reset used everywhere else

    // Assert asynchronously, release on the clock
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            rst_sync_r <= 2'h0;
        end else begin
            rst_sync_r <= {rst_sync_r[0], 1'h1};
        end
    end
    assign rst_n = rst_sync_r[1];

    // True for the register numbers that make an encoding unpredictable
    function automatic logic bad_reg(input logic [3:0] r);
        bad_reg = (r == `UDMS_REG_SP) || (r == `UDMS_REG_PC);
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Decode stage
    logic [15:0] hw1; // First halfword of a wide encoding
    logic [15:0] hw2; // Second halfword, or the narrow encoding
    assign hw1 = instr[31:16];
    assign hw2 = instr[15:0];

    logic s1_valid_r, s1_valid_nxt; // Decoded operation pending
    udms_pkg::udms_op_t s1_op_r, s1_op_nxt; // Decoded operation
    logic [3:0] s1_n_r, s1_n_nxt; // First operand register
    logic [3:0] s1_m_r, s1_m_nxt; // Second operand register
    logic [3:0] s1_dlo_r, s1_dlo_nxt; // Destination, or low half
    logic [3:0] s1_dhi_r, s1_dhi_nxt; // High destination
    logic [4:0] s1_amt_r, s1_amt_nxt; // Shift or rotate amount
    logic s1_sh_r, s1_sh_nxt; // shift_type_bit of saturate
    logic [4:0] s1_pos_r, s1_pos_nxt; // Saturation bit position
    logic s1_undef_r, s1_undef_nxt; // Undefined encoding seen
    logic s1_unpred_r, s1_unpred_nxt; // Unpredictable encoding seen

    // Match opcode bits and pull fields; should-be bits are not looked at
    always_comb begin
        s1_valid_nxt = 1'h0;
        s1_op_nxt = udms_pkg::op_none;
        s1_n_nxt = hw1[3:0];
        s1_m_nxt = hw2[3:0];
        s1_dlo_nxt = hw2[11:8];
        s1_dhi_nxt = hw2[11:8];
        s1_amt_nxt = 5'h0;
        s1_sh_nxt = 1'h0;
        s1_pos_nxt = hw2[4:0];
        s1_undef_nxt = 1'h0;
        s1_unpred_nxt = 1'h0;
        if (instr_valid && instr_is_16) begin
            // Narrow extends: low registers only, no rotation
            s1_m_nxt = {1'h0, hw2[5:3]}; // see RULE_16
            s1_dlo_nxt = {1'h0, hw2[2:0]}; // see RULE_16
            if (hw2[15:6] == `UDMS_XTB16) begin
                s1_valid_nxt = 1'h1;
                s1_op_nxt = udms_pkg::op_zero_extend_byte;
            end else if (hw2[15:6] == `UDMS_XTH16) begin
                s1_valid_nxt = 1'h1;
                s1_op_nxt = udms_pkg::op_zero_extend_half;
            end
        end else if (instr_valid) begin
            if (hw1[15:4] == `UDMS_DIV_HW1 && hw2[7:4] == 4'hf) begin // see RULE_18
                // Rd, Rn, Rm from three nibbles
                s1_valid_nxt = 1'h1; // see RULE_02
                s1_op_nxt = udms_pkg::op_unsigned_divide;
                // Executed anyway, only reported
                s1_unpred_nxt = bad_reg(hw2[11:8]) || bad_reg(hw1[3:0])
                    || bad_reg(hw2[3:0]); // see RULE_03
            end else if ((hw1[15:4] == `UDMS_MLAL_HW1 || hw1[15:4] == `UDMS_MULL_HW1)
                && hw2[7:4] == 4'h0) begin
                s1_valid_nxt = 1'h1;
                s1_op_nxt = (hw1[15:4] == `UDMS_MLAL_HW1)
                    ? udms_pkg::op_unsigned_mul_acc_long : udms_pkg::op_unsigned_mul_long;
                s1_dlo_nxt = hw2[15:12];
                s1_dhi_nxt = hw2[11:8];
                s1_unpred_nxt = bad_reg(hw2[15:12]) || bad_reg(hw2[11:8])
                    || bad_reg(hw1[3:0]) || bad_reg(hw2[3:0])
                    || (hw2[15:12] == hw2[11:8]); // see RULE_09
            end else if (hw1[15:11] == `UDMS_SAT_HI5 && hw1[9:6] == `UDMS_SAT_MID4
                && !hw1[4] && !hw2[15]) begin
                s1_sh_nxt = hw1[5];
                s1_amt_nxt = {hw2[14:12], hw2[7:6]};
                s1_unpred_nxt = bad_reg(hw2[11:8]) || bad_reg(hw1[3:0]);
                // Arithmetic shift of zero is no instruction at all
                if (hw1[5] && s1_amt_nxt == 5'h0) begin
                    s1_undef_nxt = 1'h1; // see RULE_12
                    s1_unpred_nxt = 1'h0;
                end else begin
                    s1_valid_nxt = 1'h1;
                    s1_op_nxt = udms_pkg::op_unsigned_saturate;
                end
            end else if ((hw1 == `UDMS_XTB_HW1 || hw1 == `UDMS_XTH_HW1)
                && hw2[15:12] == 4'hf && hw2[7]) begin
                s1_valid_nxt = 1'h1;
                s1_op_nxt = (hw1 == `UDMS_XTB_HW1)
                    ? udms_pkg::op_zero_extend_byte : udms_pkg::op_zero_extend_half;
                s1_amt_nxt = {hw2[5:4], 3'h0}; // see RULE_15
                s1_unpred_nxt = bad_reg(hw2[11:8]) || bad_reg(hw2[3:0]); // see RULE_15
            end
        end
    end

    // Decode registers; their numbers drive the register file read
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s1_valid_r <= 1'h0;
            s1_op_r <= udms_pkg::op_none;
            s1_n_r <= 4'h0;
            s1_m_r <= 4'h0;
            s1_dlo_r <= 4'h0;
            s1_dhi_r <= 4'h0;
            s1_amt_r <= 5'h0;
            s1_sh_r <= 1'h0;
            s1_pos_r <= 5'h0;
            s1_undef_r <= 1'h0;
            s1_unpred_r <= 1'h0;
        end else begin
            s1_valid_r <= s1_valid_nxt;
            s1_op_r <= s1_op_nxt;
            s1_n_r <= s1_n_nxt;
            s1_m_r <= s1_m_nxt;
            s1_dlo_r <= s1_dlo_nxt;
            s1_dhi_r <= s1_dhi_nxt;
            s1_amt_r <= s1_amt_nxt;
            s1_sh_r <= s1_sh_nxt;
            s1_pos_r <= s1_pos_nxt;
            s1_undef_r <= s1_undef_nxt;
            s1_unpred_r <= s1_unpred_nxt;
        end
    end
    assign rf_addr_n = s1_n_r;
    assign rf_addr_m = s1_m_r;
    assign rf_addr_dlo = s1_dlo_r;
    assign rf_addr_dhi = s1_dhi_r;

    ////////////////////////////////////////////////////////////////////////
    // Execute stage
    logic [63:0] prod; // Full unsigned product
    logic [63:0] acc_sum; // Product plus destination pair
    logic [31:0] rot_val; // Rotated source for the extends
    logic [31:0] sat_in; // Shifted saturate operand
    logic [31:0] sat_max; // Top of the unsigned range
    logic [63:0] rot_dbl; // Source twice, for rotation by shift

    assign prod = rf_val_n * rf_val_m; // see RULE_07
    assign acc_sum = prod + {rf_val_dhi, rf_val_dlo}; // see RULE_06
    assign rot_dbl = {rf_val_m, rf_val_m} >> s1_amt_r;
    assign rot_val = rot_dbl[31:0];
    // Carry in plays no part in either shift
    assign sat_in = s1_sh_r ? 32'($signed(rf_val_n) >>> s1_amt_r)
        : (rf_val_n << s1_amt_r); // see RULE_13
    assign sat_max = (32'h1 << s1_pos_r) - 32'h1;

    logic wb_lo_en_r, wb_lo_en_nxt; // Low write enable
    logic [3:0] wb_lo_addr_r, wb_lo_addr_nxt; // Low write register
    logic [31:0] wb_lo_data_r, wb_lo_data_nxt; // Low write data
    logic wb_hi_en_r, wb_hi_en_nxt; // High write enable
    logic [3:0] wb_hi_addr_r, wb_hi_addr_nxt; // High write register
    logic [31:0] wb_hi_data_r, wb_hi_data_nxt; // High write data
    logic sat_r, sat_nxt; // Sticky saturation flag
    logic fault_r, fault_nxt; // Divide by zero trap pulse
    logic undef_r, undef_nxt; // Undefined encoding pulse
    logic unpred_r, unpred_nxt; // Unpredictable encoding pulse
    logic sat_hit; // This cycle's saturate clamped

    // Results; no flag outputs exist, so flags stay as they were
    always_comb begin
        wb_lo_en_nxt = s1_valid_r;
        wb_lo_addr_nxt = s1_dlo_r;
        wb_lo_data_nxt = 32'h0;
        wb_hi_en_nxt = 1'h0;
        wb_hi_addr_nxt = s1_dhi_r;
        wb_hi_data_nxt = 32'h0;
        fault_nxt = 1'h0;
        sat_hit = 1'h0;
        unique case (s1_op_r)
            udms_pkg::op_unsigned_divide: begin
                if (rf_val_m == 32'h0) begin
                    // Trap enable read at execute time
                    fault_nxt = div_zero_trap_enable; // see RULE_04, see RULE_19
                    wb_lo_en_nxt = !div_zero_trap_enable; // see RULE_04
                end else begin
                    wb_lo_data_nxt = rf_val_n / rf_val_m; // see RULE_01, see RULE_05
                end
            end
            udms_pkg::op_unsigned_mul_acc_long: begin
                wb_lo_data_nxt = acc_sum[31:0]; // see RULE_06
                wb_hi_data_nxt = acc_sum[63:32];
                wb_hi_en_nxt = s1_valid_r;
            end
            udms_pkg::op_unsigned_mul_long: begin
                wb_lo_data_nxt = prod[31:0]; // see RULE_08
                wb_hi_data_nxt = prod[63:32]; // see RULE_08
                wb_hi_en_nxt = s1_valid_r; // see RULE_09
            end
            udms_pkg::op_unsigned_saturate: begin
                // Negative clamps to zero, large to the top
                if (sat_in[31]) begin
                    wb_lo_data_nxt = 32'h0; // see RULE_10
                    sat_hit = s1_valid_r;
                end else if (sat_in > sat_max) begin
                    wb_lo_data_nxt = sat_max; // see RULE_10
                    sat_hit = s1_valid_r;
                end else begin
                    wb_lo_data_nxt = sat_in;
                end
            end
            udms_pkg::op_zero_extend_byte: begin
                wb_lo_data_nxt = {24'h0, rot_val[7:0]}; // see RULE_14
            end
            udms_pkg::op_zero_extend_half: begin
                wb_lo_data_nxt = {16'h0, rot_val[15:0]}; // see RULE_17
            end
            udms_pkg::op_none: begin
                wb_lo_en_nxt = 1'h0;
            end
        endcase
        // Set beats a clear in the same cycle; only software or reset clears
        sat_nxt = sat_hit ? 1'h1 : (sat_flag_clr ? 1'h0 : sat_r); // see RULE_11
        undef_nxt = s1_undef_r;
        unpred_nxt = s1_unpred_r && s1_valid_r;
    end

    // Result registers feed the ports directly
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wb_lo_en_r <= 1'h0;
            wb_lo_addr_r <= 4'h0;
            wb_lo_data_r <= 32'h0;
            wb_hi_en_r <= 1'h0;
            wb_hi_addr_r <= 4'h0;
            wb_hi_data_r <= 32'h0;
            sat_r <= `UDMS_RST_SAT;
            fault_r <= 1'h0;
            undef_r <= 1'h0;
            unpred_r <= 1'h0;
        end else begin
            wb_lo_en_r <= wb_lo_en_nxt;
            wb_lo_addr_r <= wb_lo_addr_nxt;
            wb_lo_data_r <= wb_lo_data_nxt;
            wb_hi_en_r <= wb_hi_en_nxt;
            wb_hi_addr_r <= wb_hi_addr_nxt;
            wb_hi_data_r <= wb_hi_data_nxt;
            sat_r <= sat_nxt;
            fault_r <= fault_nxt;
            undef_r <= undef_nxt;
            unpred_r <= unpred_nxt;
        end
    end
    assign wb_lo_en = wb_lo_en_r;
    assign wb_lo_addr = wb_lo_addr_r;
    assign wb_lo_data = wb_lo_data_r;
    assign wb_hi_en = wb_hi_en_r;
    assign wb_hi_addr = wb_hi_addr_r;
    assign wb_hi_data = wb_hi_data_r;
    assign sticky_saturation_flag = sat_r;
    assign usage_fault_exception = fault_r;
    assign undefined_instr = undef_r;
    assign unpredictable_op = unpred_r;

    ////////////////////////////////////////////////////////////////////////
    // Checks
    a_div_zero_res: assert property (@(posedge clk) disable iff (!rst_n)
        $past(s1_op_r == udms_pkg::op_unsigned_divide && s1_valid_r
        && rf_val_m == 32'h0) |-> (fault_r == $past(div_zero_trap_enable))
        && (wb_lo_en_r != fault_r) && (wb_lo_data_r == 32'h0)) // see RULE_04
        else $error("Zero divisor handled wrongly");
    a_div_quot: assert property (@(posedge clk) disable iff (!rst_n)
        $past(s1_op_r == udms_pkg::op_unsigned_divide && s1_valid_r
        && rf_val_m != 32'h0) |-> wb_lo_en_r && !fault_r
        && wb_lo_data_r * $past(rf_val_m) <= {32'h0, $past(rf_val_n)}
        && ({32'h0, wb_lo_data_r} + 64'h1) * {32'h0, $past(rf_val_m)}
        > {32'h0, $past(rf_val_n)}) // see RULE_05
        else $error("Quotient not truncated");
    a_mull_split: assert property (@(posedge clk) disable iff (!rst_n)
        $past(s1_op_r == udms_pkg::op_unsigned_mul_long && s1_valid_r)
        |-> {wb_hi_data_r, wb_lo_data_r} == $past(rf_val_n) * $past(rf_val_m)
        && wb_hi_en_r && wb_lo_en_r) // see RULE_08
        else $error("Long product misplaced");
    a_mlal_sum: assert property (@(posedge clk) disable iff (!rst_n)
        $past(s1_op_r == udms_pkg::op_unsigned_mul_acc_long && s1_valid_r)
        |-> {wb_hi_data_r, wb_lo_data_r} == $past(rf_val_n) * $past(rf_val_m)
        + {$past(rf_val_dhi), $past(rf_val_dlo)}) // see RULE_06
        else $error("Accumulate sum wrong");
    a_sat_sticky: assert property (@(posedge clk) disable iff (!rst_n)
        $past(sat_r) && !$past(sat_flag_clr) |-> sat_r) // see RULE_11
        else $error("Sticky flag lost");
    a_sat_range: assert property (@(posedge clk) disable iff (!rst_n)
        $past(s1_op_r == udms_pkg::op_unsigned_saturate && s1_valid_r)
        |-> wb_lo_data_r <= (32'h1 << $past(s1_pos_r)) - 32'h1
        && (wb_lo_data_r == $past(sat_in) || sat_r)) // see RULE_10
        else $error("Saturate out of range");
    a_undef_sat: assert property (@(posedge clk) disable iff (!rst_n)
        instr_valid && !instr_is_16 && hw1[15:11] == `UDMS_SAT_HI5
        && hw1[9:6] == `UDMS_SAT_MID4 && !hw1[4] && !hw2[15] && hw1[5]
        && hw2[14:12] == 3'h0 && hw2[7:6] == 2'h0
        |-> ##2 undefined_instr && !wb_lo_en_r) // see RULE_12
        else $error("Undefined saturate executed");
    a_xtb_narrow: assert property (@(posedge clk) disable iff (!rst_n)
        instr_valid && instr_is_16 && hw2[15:6] == `UDMS_XTB16
        |-> ##1 rf_addr_m[3] == 1'h0 && rf_addr_dlo == {1'h0, $past(hw2[2:0])}
        ##1 wb_lo_en_r && wb_lo_data_r == {24'h0, $past(rf_val_m[7:0])}) // see RULE_16
        else $error("Narrow byte extend wrong");

endmodule // udms_top

`default_nettype wire
